// *** pgtm_pkg.sv ***
// package: register map, field positions and reset values of the power-good mask bank
`default_nettype none
package pgtm_pkg;
	localparam int          PGTM_DW                = 8;
	localparam int          PGTM_AW                = 8;
	// register offsets
	localparam logic [7:0]  PGTM_OFS_OUT2_REGS     = 8'hA8;
	localparam logic [7:0]  PGTM_OFS_OUT2_CTRL_LDO = 8'hA9;
	localparam logic [7:0]  PGTM_OFS_OUT3_REGS     = 8'hAA;
	localparam logic [7:0]  PGTM_OFS_OUT3_CTRL_LDO = 8'hAB;
	localparam logic [7:0]  PGTM_OFS_MISC_CTRL     = 8'hAC;
	// reset values
	localparam logic [7:0]  PGTM_RST_OUT2_REGS     = 8'hC0;
	localparam logic [7:0]  PGTM_RST_OUT2_CTRL_LDO = 8'h2F;
	localparam logic [7:0]  PGTM_RST_OUT3_REGS     = 8'h00;
	localparam logic [7:0]  PGTM_RST_OUT3_CTRL_LDO = 8'h00;
	localparam logic [7:0]  PGTM_RST_MISC_CTRL     = 8'hFF;
	localparam logic [7:0]  PGTM_RDATA_UNMAPPED    = 8'h00;
	// regulator register fields
	localparam int          PGTM_BIT_AUX_LDO2      = 7;
	localparam int          PGTM_BIT_LOAD_SW_A1    = 6;
	localparam int          PGTM_BIT_STEPDOWN_HI   = 5;
	localparam int          PGTM_BIT_STEPDOWN_LO   = 0;
	// control/ldo register fields
	localparam int          PGTM_BIT_CTRL_IN5      = 7;
	localparam int          PGTM_BIT_CTRL_IN4      = 6;
	localparam int          PGTM_BIT_CTRL_IN2      = 5;
	localparam int          PGTM_BIT_CTRL_IN1      = 4;
	localparam int          PGTM_BIT_TERM_LDO      = 3;
	localparam int          PGTM_BIT_LOAD_SW_B2    = 2;
	localparam int          PGTM_BIT_LOAD_SW_B1    = 1;
	localparam int          PGTM_BIT_AUX_LDO3      = 0;
	// misc register fields for the two outputs of this bank
	localparam int          PGTM_BIT_OUT2_CTRL_IN3 = 3;
	localparam int          PGTM_BIT_OUT2_CTRL_IN6 = 2;
	localparam int          PGTM_BIT_OUT3_CTRL_IN3 = 1;
	localparam int          PGTM_BIT_OUT3_CTRL_IN6 = 0;
	// sources per tree: two full registers plus ctrl_in3 and ctrl_in6
	localparam int          PGTM_TREE_W            = 18;
	localparam int          PGTM_NUM_STEPDOWN      = 6;
	localparam int          PGTM_NUM_CTRL_IN       = 6;
endpackage
`default_nettype wire

// *** pgtm_tree.sv ***
// module: masked power-good combining tree for one output
`timescale 1ns/1ps
`default_nettype none
module pgtm_tree #(
	parameter int N = 18
) (
	input  wire logic [N-1:0] i_src_good,
	input  wire logic [N-1:0] i_mask,
	output logic              o_good
);
	// a set mask bit forces its leg true so it cannot pull the result low
	assign o_good = &(i_src_good | i_mask);
endmodule
`default_nettype wire

// *** pgtm_regs.sv ***
// module: power-good tree mask registers for outputs two and three
`timescale 1ns/1ps
`default_nettype none
module pgtm_regs #(
	parameter int NUM_STEPDOWN = pgtm_pkg::PGTM_NUM_STEPDOWN,
	parameter int NUM_CTRL_IN  = pgtm_pkg::PGTM_NUM_CTRL_IN
) (
	input  wire logic                        I_CLK,
	input  wire logic                        I_NRST,
	input  wire logic                        I_REG_WE,
	input  wire logic [pgtm_pkg::PGTM_AW-1:0] I_REG_ADDR,
	input  wire logic [pgtm_pkg::PGTM_DW-1:0] I_REG_WDATA,
	output logic      [pgtm_pkg::PGTM_DW-1:0] O_REG_RDATA,
	input  wire logic [NUM_STEPDOWN-1:0]     I_STEPDOWN_PG,
	input  wire logic                        I_AUX_LDO2_PG,
	input  wire logic                        I_AUX_LDO3_PG,
	input  wire logic                        I_LOAD_SW_A1_PG,
	input  wire logic                        I_LOAD_SW_B1_PG,
	input  wire logic                        I_LOAD_SW_B2_PG,
	input  wire logic                        I_TERM_LDO_PG,
	input  wire logic [NUM_CTRL_IN-1:0]      I_CTRL_IN,
	output logic                             O_PGOOD_OUT2,
	output logic                             O_PGOOD_OUT2_OE,
	output logic                             O_PGOOD_OUT3,
	output logic                             O_PGOOD_OUT3_OE
);
	localparam int SW = NUM_STEPDOWN + NUM_CTRL_IN + 6;

	// mask registers
	logic [7:0] out2_pg_mask_regulators_r;
	logic [7:0] out2_pg_mask_ctrl_ldo_r;
	logic [7:0] out3_pg_mask_regulators_r;
	logic [7:0] out3_pg_mask_ctrl_ldo_r;
	logic [7:0] misc_pg_mask_ctrl_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// source status crosses in from analog comparators and pins
	logic [SW-1:0] src_raw;
	logic [SW-1:0] src_meta_r;
	logic [SW-1:0] src_sync_r;

	logic [NUM_STEPDOWN-1:0] stepdown_pg;
	logic                    aux_ldo2_pg;
	logic                    aux_ldo3_pg;
	logic                    load_sw_a1_pg;
	logic                    load_sw_b1_pg;
	logic                    load_sw_b2_pg;
	logic                    term_ldo_pg;
	logic [NUM_CTRL_IN-1:0]  ctrl_in;

	logic [7:0] regs_src;
	logic [7:0] ctrl_ldo_src;
	logic [pgtm_pkg::PGTM_TREE_W-1:0] out2_src;
	logic [pgtm_pkg::PGTM_TREE_W-1:0] out3_src;
	logic [pgtm_pkg::PGTM_TREE_W-1:0] out2_mask;
	logic [pgtm_pkg::PGTM_TREE_W-1:0] out3_mask;
	logic out2_good;
	logic out3_good;
	logic out2_good_r;
	logic out3_good_r;

	logic sel_out2_regs;
	logic sel_out2_ctrl_ldo;
	logic sel_out3_regs;
	logic sel_out3_ctrl_ldo;
	logic sel_misc;
	logic wr_out2_regs;
	logic wr_out2_ctrl_ldo;
	logic wr_out3_regs;
	logic wr_out3_ctrl_ldo;
	logic wr_misc;

	// address decode
	assign sel_out2_regs     = (I_REG_ADDR == pgtm_pkg::PGTM_OFS_OUT2_REGS);
	assign sel_out2_ctrl_ldo = (I_REG_ADDR == pgtm_pkg::PGTM_OFS_OUT2_CTRL_LDO);
	assign sel_out3_regs     = (I_REG_ADDR == pgtm_pkg::PGTM_OFS_OUT3_REGS);
	assign sel_out3_ctrl_ldo = (I_REG_ADDR == pgtm_pkg::PGTM_OFS_OUT3_CTRL_LDO);
	assign sel_misc          = (I_REG_ADDR == pgtm_pkg::PGTM_OFS_MISC_CTRL);

	assign wr_out2_regs     = I_REG_WE & sel_out2_regs;
	assign wr_out2_ctrl_ldo = I_REG_WE & sel_out2_ctrl_ldo;
	assign wr_out3_regs     = I_REG_WE & sel_out3_regs;
	assign wr_out3_ctrl_ldo = I_REG_WE & sel_out3_ctrl_ldo;
	assign wr_misc          = I_REG_WE & sel_misc;

	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
		begin
			out2_pg_mask_regulators_r <= pgtm_pkg::PGTM_RST_OUT2_REGS;
			out2_pg_mask_ctrl_ldo_r   <= pgtm_pkg::PGTM_RST_OUT2_CTRL_LDO;
			out3_pg_mask_regulators_r <= pgtm_pkg::PGTM_RST_OUT3_REGS;
			out3_pg_mask_ctrl_ldo_r   <= pgtm_pkg::PGTM_RST_OUT3_CTRL_LDO;
			misc_pg_mask_ctrl_r       <= pgtm_pkg::PGTM_RST_MISC_CTRL;
		end
		else
		begin
			if (wr_out2_regs)
				out2_pg_mask_regulators_r <= I_REG_WDATA;
			if (wr_out2_ctrl_ldo)
				out2_pg_mask_ctrl_ldo_r <= I_REG_WDATA;
			if (wr_out3_regs)
				out3_pg_mask_regulators_r <= I_REG_WDATA;
			if (wr_out3_ctrl_ldo)
				out3_pg_mask_ctrl_ldo_r <= I_REG_WDATA;
			if (wr_misc)
				misc_pg_mask_ctrl_r <= I_REG_WDATA;
		end
	end

	// read mux; unmapped offsets read zero so software can probe safely
	always_comb
	begin
		if (sel_out2_regs)
			rdata_nxt = out2_pg_mask_regulators_r;
		else if (sel_out2_ctrl_ldo)
			rdata_nxt = out2_pg_mask_ctrl_ldo_r;
		else if (sel_out3_regs)
			rdata_nxt = out3_pg_mask_regulators_r;
		else if (sel_out3_ctrl_ldo)
			rdata_nxt = out3_pg_mask_ctrl_ldo_r;
		else if (sel_misc)
			rdata_nxt = misc_pg_mask_ctrl_r;
		else
			rdata_nxt = pgtm_pkg::PGTM_RDATA_UNMAPPED;
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
			rdata_r <= pgtm_pkg::PGTM_RDATA_UNMAPPED;
		else
			rdata_r <= rdata_nxt;
	end

	// two-stage synchroniser on every status input
	assign src_raw = {I_CTRL_IN, I_TERM_LDO_PG, I_LOAD_SW_B2_PG, I_LOAD_SW_B1_PG,
		I_LOAD_SW_A1_PG, I_AUX_LDO3_PG, I_AUX_LDO2_PG, I_STEPDOWN_PG};

	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
		begin
			src_meta_r <= '0;
			src_sync_r <= '0;
		end
		else
		begin
			src_meta_r <= src_raw;
			src_sync_r <= src_meta_r;
		end
	end

	assign stepdown_pg   = src_sync_r[NUM_STEPDOWN-1:0];
	assign aux_ldo2_pg   = src_sync_r[NUM_STEPDOWN];
	assign aux_ldo3_pg   = src_sync_r[NUM_STEPDOWN+1];
	assign load_sw_a1_pg = src_sync_r[NUM_STEPDOWN+2];
	assign load_sw_b1_pg = src_sync_r[NUM_STEPDOWN+3];
	assign load_sw_b2_pg = src_sync_r[NUM_STEPDOWN+4];
	assign term_ldo_pg   = src_sync_r[NUM_STEPDOWN+5];
	assign ctrl_in       = src_sync_r[SW-1:NUM_STEPDOWN+6];

	// arrange sources in the same bit order as the mask registers
	always_comb
	begin
		regs_src = 8'h00;
		regs_src[pgtm_pkg::PGTM_BIT_AUX_LDO2]   = aux_ldo2_pg;
		regs_src[pgtm_pkg::PGTM_BIT_LOAD_SW_A1] = load_sw_a1_pg;
		regs_src[pgtm_pkg::PGTM_BIT_STEPDOWN_HI:pgtm_pkg::PGTM_BIT_STEPDOWN_LO] = stepdown_pg;
	end

	always_comb
	begin
		ctrl_ldo_src = 8'h00;
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_CTRL_IN5]   = ctrl_in[4];
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_CTRL_IN4]   = ctrl_in[3];
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_CTRL_IN2]   = ctrl_in[1];
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_CTRL_IN1]   = ctrl_in[0];
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_TERM_LDO]   = term_ldo_pg;
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_LOAD_SW_B2] = load_sw_b2_pg;
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_LOAD_SW_B1] = load_sw_b1_pg;
		ctrl_ldo_src[pgtm_pkg::PGTM_BIT_AUX_LDO3]   = aux_ldo3_pg;
	end

	// both outputs share the source layout; only the masks differ
	assign out2_src = {ctrl_in[5], ctrl_in[2], ctrl_ldo_src, regs_src};
	assign out3_src = out2_src;

	assign out2_mask = {misc_pg_mask_ctrl_r[pgtm_pkg::PGTM_BIT_OUT2_CTRL_IN6],
		misc_pg_mask_ctrl_r[pgtm_pkg::PGTM_BIT_OUT2_CTRL_IN3],
		out2_pg_mask_ctrl_ldo_r, out2_pg_mask_regulators_r};
	assign out3_mask = {misc_pg_mask_ctrl_r[pgtm_pkg::PGTM_BIT_OUT3_CTRL_IN6],
		misc_pg_mask_ctrl_r[pgtm_pkg::PGTM_BIT_OUT3_CTRL_IN3],
		out3_pg_mask_ctrl_ldo_r, out3_pg_mask_regulators_r};

	pgtm_tree #(
		.N (pgtm_pkg::PGTM_TREE_W)
	) u_tree_out2 (
		.i_src_good (out2_src),
		.i_mask     (out2_mask),
		.o_good     (out2_good)
	);

	pgtm_tree #(
		.N (pgtm_pkg::PGTM_TREE_W)
	) u_tree_out3 (
		.i_src_good (out3_src),
		.i_mask     (out3_mask),
		.o_good     (out3_good)
	);

	// outputs held not-good in reset so the open-drain pins pull low
	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
		begin
			out2_good_r <= 1'b0;
			out3_good_r <= 1'b0;
		end
		else
		begin
			out2_good_r <= out2_good;
			out3_good_r <= out3_good;
		end
	end

	assign O_REG_RDATA     = rdata_r;
	assign O_PGOOD_OUT2    = out2_good_r;
	assign O_PGOOD_OUT3    = out3_good_r;
	// open drain: drive low only while not good
	logic oe2_r;
	logic oe3_r;
	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
		begin
			oe2_r <= 1'b1;
			oe3_r <= 1'b1;
		end
		else
		begin
			oe2_r <= ~out2_good;
			oe3_r <= ~out3_good;
		end
	end
	assign O_PGOOD_OUT2_OE = oe2_r;
	assign O_PGOOD_OUT3_OE = oe3_r;
endmodule
`default_nettype wire

// *** pgtm_regs_sva.sv ***
// checker: port-level assertions for the power-good mask bank
`timescale 1ns/1ps
`default_nettype none
module pgtm_sva #(
	parameter int NUM_STEPDOWN = 6,
	parameter int NUM_CTRL_IN  = 6
) (
	input wire logic                    I_CLK,
	input wire logic                    I_NRST,
	input wire logic                    I_REG_WE,
	input wire logic [7:0]              I_REG_ADDR,
	input wire logic [7:0]              I_REG_WDATA,
	input wire logic [7:0]              O_REG_RDATA,
	input wire logic [NUM_STEPDOWN-1:0] I_STEPDOWN_PG,
	input wire logic                    I_AUX_LDO2_PG,
	input wire logic                    I_AUX_LDO3_PG,
	input wire logic                    I_LOAD_SW_A1_PG,
	input wire logic                    I_LOAD_SW_B1_PG,
	input wire logic                    I_LOAD_SW_B2_PG,
	input wire logic                    I_TERM_LDO_PG,
	input wire logic [NUM_CTRL_IN-1:0]  I_CTRL_IN,
	input wire logic                    O_PGOOD_OUT2,
	input wire logic                    O_PGOOD_OUT2_OE,
	input wire logic                    O_PGOOD_OUT3,
	input wire logic                    O_PGOOD_OUT3_OE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	wire [NUM_STEPDOWN+NUM_CTRL_IN+5:0] srcs = {I_CTRL_IN, I_TERM_LDO_PG, I_LOAD_SW_B2_PG, I_LOAD_SW_B1_PG,
		I_AUX_LDO3_PG, I_AUX_LDO2_PG, I_LOAD_SW_A1_PG, I_STEPDOWN_PG};
	wire                                map_hit = I_REG_ADDR >= 8'hA8 && I_REG_ADDR <= 8'hAC;
	oe_out2_a: assert property (O_PGOOD_OUT2_OE == !O_PGOOD_OUT2) else $error("out2 enable wrong");
	oe_out3_a: assert property (O_PGOOD_OUT3_OE == !O_PGOOD_OUT3) else $error("out3 enable wrong");
	rst_out_a: assert property ($rose(I_NRST) |-> !O_PGOOD_OUT2 && !O_PGOOD_OUT3) else $error("good in reset");
	rst_a9_a: assert property ($rose(I_NRST) && !I_REG_WE && I_REG_ADDR == 8'hA9 |=> O_REG_RDATA == 8'h2F)
		else $error("second out2 mask reset value wrong");
	wr_rd_a: assert property (I_REG_WE && map_hit ##1 !I_REG_WE && $stable(I_REG_ADDR)
		|=> O_REG_RDATA == $past(I_REG_WDATA, 2)) else $error("read back differs from write");
	unmap_rd_a: assert property (!map_hit |=> O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
	// synchroniser flush after reset would look like a change, so reset must be steady too
	stab_out2_a: assert property (($stable(srcs) && !I_REG_WE && $stable(I_NRST))[*4]
		|=> $stable(O_PGOOD_OUT2)) else $error("out2 moved with steady causes");
	stab_out3_a: assert property (($stable(srcs) && !I_REG_WE && $stable(I_NRST))[*4]
		|=> $stable(O_PGOOD_OUT3)) else $error("out3 moved with steady causes");
endmodule
bind pgtm_regs pgtm_sva #(.NUM_STEPDOWN(NUM_STEPDOWN), .NUM_CTRL_IN(NUM_CTRL_IN)) pgtm_sva_inst (
	.I_CLK(I_CLK), .I_NRST(I_NRST), .I_REG_WE(I_REG_WE), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
	.O_REG_RDATA(O_REG_RDATA), .I_STEPDOWN_PG(I_STEPDOWN_PG), .I_AUX_LDO2_PG(I_AUX_LDO2_PG),
	.I_AUX_LDO3_PG(I_AUX_LDO3_PG), .I_LOAD_SW_A1_PG(I_LOAD_SW_A1_PG), .I_LOAD_SW_B1_PG(I_LOAD_SW_B1_PG),
	.I_LOAD_SW_B2_PG(I_LOAD_SW_B2_PG), .I_TERM_LDO_PG(I_TERM_LDO_PG), .I_CTRL_IN(I_CTRL_IN),
	.O_PGOOD_OUT2(O_PGOOD_OUT2), .O_PGOOD_OUT2_OE(O_PGOOD_OUT2_OE), .O_PGOOD_OUT3(O_PGOOD_OUT3),
	.O_PGOOD_OUT3_OE(O_PGOOD_OUT3_OE)
);
`default_nettype wire

// *** tb.sv ***
// testbench: register access and power-good tree checks for the mask bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk;
	logic        nrst;
	logic        we;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [17:0] src;
	wire  [7:0]  rdata;
	wire         g2;
	wire         oe2;
	wire         g3;
	wire         oe3;
	int          fails;
	int          samples_checked;
	// source order: stepdown 1..6, sw_a1, ldo2, ldo3, sw_b1, sw_b2, term, ctrl_in1..6
	pgtm_regs pgtm_regs_inst (.I_CLK(clk), .I_NRST(nrst), .I_REG_WE(we), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
		.O_REG_RDATA(rdata), .I_STEPDOWN_PG(src[5:0]), .I_LOAD_SW_A1_PG(src[6]), .I_AUX_LDO2_PG(src[7]),
		.I_AUX_LDO3_PG(src[8]), .I_LOAD_SW_B1_PG(src[9]), .I_LOAD_SW_B2_PG(src[10]), .I_TERM_LDO_PG(src[11]),
		.I_CTRL_IN(src[17:12]), .O_PGOOD_OUT2(g2), .O_PGOOD_OUT2_OE(oe2), .O_PGOOD_OUT3(g3), .O_PGOOD_OUT3_OE(oe3));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic do_reset();
		nrst = 1'b0;
		we = 1'b0;
		addr = 8'hA9;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk("rdata", e, rdata);
	endtask
	// offsets A7h..ADh, the two ends unmapped
	task automatic t_reset();
		logic [7:0] tab [7];
		tab = '{8'h00, 8'hC0, 8'h2F, 8'h00, 8'h00, 8'hFF, 8'h00};
		for (int i = 0; i < 7; i++)
			rd(8'hA7 + 8'(i), tab[i]);
		$display("reset values test done");
	endtask
	task automatic t_rw();
		logic [7:0] d;
		for (int p = 0; p < 2; p++)
		begin
			d = p ? 8'hA5 : 8'h5A;
			for (int i = 0; i < 7; i++)
			begin
				wr(8'hA7 + 8'(i), d);
				rd(8'hA7 + 8'(i), (i > 0 && i < 6) ? d : 8'h00);
			end
		end
		$display("read write test done");
	endtask
	// drop one source at a time; a masked source must leave the output good
	task automatic t_tree(input logic [17:0] m2, input logic [17:0] m3);
		src = '1;
		repeat (4) @(negedge clk);
		chk("good2 all", 8'h01, 8'(g2));
		chk("good3 all", 8'h01, 8'(g3));
		for (int b = 0; b < 18; b++)
		begin
			src = ~(18'h00001 << b);
			repeat (4) @(negedge clk);
			chk("good2", 8'(m2[b]), 8'(g2));
			chk("good3", 8'(m3[b]), 8'(g3));
			chk("oe2", 8'(!m2[b]), 8'(oe2));
			chk("oe3", 8'(!m3[b]), 8'(oe3));
		end
		src = '1;
		$display("tree test done");
	endtask
	initial
	begin
		fails = 0;
		samples_checked = 0;
		src = '1;
		wdata = 8'h00;
		do_reset();
		t_reset();
		t_tree(18'h26FC0, 18'h24000);
		wr(8'hA8, 8'h3F);
		wr(8'hA9, 8'hD0);
		wr(8'hAA, 8'hFF);
		wr(8'hAB, 8'hFF);
		wr(8'hAC, 8'hF0);
		t_tree(18'h1903F, 18'h1BFFF);
		t_rw();
		do_reset();
		t_reset();
		stop_test();
	end
	// watchdog far beyond the cycle budget at 40000 cycles; the full run needs a few hundred cycles
	initial
	begin
		#200000;
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
